// ### logic/qpbsi_top.sv
// qpbsi_top: device side of a separate-I/O burst-of-four ddr sram port.
// assumes clk_k_i/clk_k_n_i and all pins are slow against clk_i; every pin
// passes a three-stage sampler and the link edges are found from it.
//
// Functional notes
// - address and both requests are taken only at true clock rises
// - lane enables and data for beats one and three taken at true rises
// - lane enables and data for beats two and four at complement rises
// - lane enables travel with every beat; each lane written or skipped
// - first write beat one cycle after command, second at next complement
// - a write takes two full input clock cycles
// - read beats one and three leave at third and fourth true rises
// - read beats two and four leave at third and fourth complement rises
// - a read takes two full input clock cycles
// - every read and write moves exactly four beats
// - reads and writes come on alternating true rises, never together
// - read and write ports are separate and may run at once
// - one beat per true and per complement rise, double data rate
// - echo clocks change together with the read data beats
// - valid flag high while read data is valid, aligned to echo clocks
// - low lane enable writes that byte, high leaves memory unchanged
`timescale 1ns/1ps
`include "qpbsi_defs.svh"

module qpbsi_top (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      clk_k_i,
  input  wire logic                      clk_k_n_i,
  input  wire logic                      read_req_n_i,
  input  wire logic                      write_req_n_i,
  input  wire logic [`QPB_ADDR_W-1:0]    address_inputs_i,
  input  wire logic [`QPB_LANES-1:0]     byte_lane_write_n_i,
  input  wire logic [`QPB_DATA_W-1:0]    write_data_bus_i,
  output logic      [`QPB_DATA_W-1:0]    read_data_bus_o,
  output logic                           echo_out_pos_o,
  output logic                           echo_out_neg_o,
  output logic                           output_valid_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and link edges

  logic [`QPB_PIN_W-1:0]      pins_raw;
  logic [`QPB_PIN_W-1:0]      pins_s;
  logic                       k_s;
  logic                       kn_s;
  logic                       rd_n_s;
  logic                       wr_n_s;
  logic [`QPB_ADDR_W-1:0]     addr_s;
  logic [`QPB_LANES-1:0]      bw_n_s;
  logic [`QPB_DATA_W-1:0]     din_s;
  logic                       k_d_reg;
  logic                       kn_d_reg;
  logic                       k_rise;
  logic                       kn_rise;
  logic                       rd_cmd;
  logic                       wr_cmd;

  // all pins go through the same sampler so data stays aligned to clocks
  assign pins_raw = {clk_k_i, clk_k_n_i, read_req_n_i, write_req_n_i,
                     address_inputs_i, byte_lane_write_n_i,
                     write_data_bus_i};

  qpbsi_pin_sync #(
    .W       (`QPB_PIN_W),
    .RST_VAL (`QPB_PIN_RST)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .pins_i    (pins_raw),
    .stable_o  (pins_s)
  );

  // field split of the sampled vector
  assign k_s    = pins_s[`QPB_PIN_K];
  assign kn_s   = pins_s[`QPB_PIN_KN];
  assign rd_n_s = pins_s[`QPB_PIN_RD_N];
  assign wr_n_s = pins_s[`QPB_PIN_WR_N];
  assign addr_s = pins_s[`QPB_PIN_A_HI:`QPB_PIN_A_LO];
  assign bw_n_s = pins_s[`QPB_PIN_BW_HI:`QPB_PIN_BW_LO];
  assign din_s  = pins_s[`QPB_PIN_D_HI:`QPB_PIN_D_LO];

  // edge finders on the sampled link clocks
  assign k_rise  = k_s & ~k_d_reg;
  assign kn_rise = kn_s & ~kn_d_reg;

  // commands exist only at true rises; read wins if both are low
  assign rd_cmd = k_rise & ~rd_n_s;
  assign wr_cmd = k_rise & ~wr_n_s & rd_n_s;
  // with both requests high neither command fires and addr_s is unused

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      k_d_reg  <= 1'b0;
      kn_d_reg <= 1'b0;
    end else begin
      k_d_reg  <= k_s;
      kn_d_reg <= kn_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path: command queue, beat capture, staging, buffer

  qpbsi_pkg::qpbsi_wr_state_t  ws_reg;
  qpbsi_pkg::qpbsi_wr_state_t  ws_next;
  logic                        wq_v_reg;
  logic [`QPB_ADDR_W-1:0]      wq_a_reg;
  logic [`QPB_ADDR_W-1:0]      wa_reg;
  logic                        wr_b0;
  logic                        wr_b1;
  logic                        wr_b2;
  logic                        wr_b3;
  logic                        cap_en;
  logic [`QPB_BEAT_W-1:0]      cap_beat;
  logic [`QPB_ADDR_W-1:0]      cap_base;
  logic                        stg_v_reg;
  logic [`QPB_BEAT_PW-1:0]     stg_reg;
  logic                        buf_in_ready;
  logic                        buf_out_valid;
  logic                        buf_out_ready;
  logic [`QPB_BEAT_PW-1:0]     buf_out_data;
  logic [`QPB_WORD_A_W-1:0]    stg_wa;
  logic [`QPB_LANES-1:0]       stg_bw_n;
  logic [`QPB_DATA_W-1:0]      stg_d;
  logic [`QPB_WORD_A_W-1:0]    hd_wa;
  logic [`QPB_LANES-1:0]       hd_bw_n;
  logic [`QPB_DATA_W-1:0]      hd_d;
  logic                        mem_we;
  logic                        fetch_en;

  // beat strobes: true rises carry beats 1 and 3, complement rises 2 and 4
  assign wr_b0 = k_rise & wq_v_reg & (ws_reg == qpbsi_pkg::WS_IDLE);
  assign wr_b1 = kn_rise & (ws_reg == qpbsi_pkg::WS_B1);
  assign wr_b2 = k_rise & (ws_reg == qpbsi_pkg::WS_B2);
  assign wr_b3 = kn_rise & (ws_reg == qpbsi_pkg::WS_B3);
  assign cap_en   = wr_b0 | wr_b1 | wr_b2 | wr_b3;
  assign cap_beat = {wr_b2 | wr_b3, wr_b1 | wr_b3};
  assign cap_base = wr_b0 ? wq_a_reg : wa_reg;

  // write sequencer: four beats over two cycles, then idle
  always_comb begin
    ws_next = ws_reg;
    case (ws_reg)
      qpbsi_pkg::WS_IDLE: if (wr_b0) ws_next = qpbsi_pkg::WS_B1;
      qpbsi_pkg::WS_B1:   if (wr_b1) ws_next = qpbsi_pkg::WS_B2;
      qpbsi_pkg::WS_B2:   if (wr_b2) ws_next = qpbsi_pkg::WS_B3;
      qpbsi_pkg::WS_B3:   if (wr_b3) ws_next = qpbsi_pkg::WS_IDLE;
      default:            ws_next = qpbsi_pkg::WS_IDLE;
    endcase
  end

  // command queue holds the address one cycle ahead of its data
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ws_reg   <= qpbsi_pkg::WS_IDLE;
      wq_v_reg <= 1'b0;
      wq_a_reg <= '0;
      wa_reg   <= '0;
    end else begin
      ws_reg <= ws_next;
      if (k_rise) begin
        wq_v_reg <= wr_cmd;
      end
      if (wr_cmd) begin
        wq_a_reg <= addr_s;
      end
      if (wr_b0) begin
        wa_reg <= wq_a_reg;
      end
    end
  end

  // staging register takes each new beat at once and clears only when the buffer has room
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stg_v_reg <= 1'b0;
      stg_reg   <= '0;
    end else if (cap_en) begin
      stg_v_reg <= 1'b1;
      stg_reg   <= {cap_base, cap_beat, bw_n_s, din_s};
    end else if (buf_in_ready) begin
      stg_v_reg <= 1'b0;
    end
  end

  // drain stalls whenever a read fetch owns the array
  assign buf_out_ready = ~fetch_en;

  qpbsi_skid_buf #(
    .W (`QPB_BEAT_PW)
  ) u_beat_buf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (stg_v_reg),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (stg_reg),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );

  // unpack staged and head beats
  assign stg_wa   = stg_reg[`QPB_BEAT_PW-1 -: `QPB_WORD_A_W];
  assign stg_bw_n = stg_reg[`QPB_PIN_BW_HI:`QPB_PIN_BW_LO];
  assign stg_d    = stg_reg[`QPB_PIN_D_HI:`QPB_PIN_D_LO];
  assign hd_wa    = buf_out_data[`QPB_BEAT_PW-1 -: `QPB_WORD_A_W];
  assign hd_bw_n  = buf_out_data[`QPB_PIN_BW_HI:`QPB_PIN_BW_LO];
  assign hd_d     = buf_out_data[`QPB_PIN_D_HI:`QPB_PIN_D_LO];
  assign mem_we   = buf_out_valid & buf_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // read path: latency pipe, beat sequencer, fetch

  qpbsi_pkg::qpbsi_rd_state_t  rs_reg;
  qpbsi_pkg::qpbsi_rd_state_t  rs_next;
  logic                        rp1_v_reg;
  logic [`QPB_ADDR_W-1:0]      rp1_a_reg;
  logic                        rp2_v_reg;
  logic [`QPB_ADDR_W-1:0]      rp2_a_reg;
  logic [`QPB_ADDR_W-1:0]      ra_reg;
  logic                        rd_b0;
  logic                        rd_b1;
  logic                        rd_b2;
  logic                        rd_b3;
  logic [`QPB_WORD_A_W-1:0]    fetch_wa;
  logic [`QPB_DATA_W-1:0]      fetch_word;

  // second true rise after the command starts the burst
  assign rd_b0 = k_rise & rp2_v_reg & (rs_reg == qpbsi_pkg::RS_IDLE);
  assign rd_b1 = kn_rise & (rs_reg == qpbsi_pkg::RS_B1);
  assign rd_b2 = k_rise & (rs_reg == qpbsi_pkg::RS_B2);
  assign rd_b3 = kn_rise & (rs_reg == qpbsi_pkg::RS_B3);
  assign fetch_en = rd_b0 | rd_b1 | rd_b2 | rd_b3;
  assign fetch_wa = {rd_b0 ? rp2_a_reg : ra_reg,
                     rd_b2 | rd_b3, rd_b1 | rd_b3};

  // read sequencer, independent of the write sequencer
  always_comb begin
    rs_next = rs_reg;
    case (rs_reg)
      qpbsi_pkg::RS_IDLE: if (rd_b0) rs_next = qpbsi_pkg::RS_B1;
      qpbsi_pkg::RS_B1:   if (rd_b1) rs_next = qpbsi_pkg::RS_B2;
      qpbsi_pkg::RS_B2:   if (rd_b2) rs_next = qpbsi_pkg::RS_B3;
      qpbsi_pkg::RS_B3:   if (rd_b3) rs_next = qpbsi_pkg::RS_IDLE;
      default:            rs_next = qpbsi_pkg::RS_IDLE;
    endcase
  end

  // two-rise latency pipe for read commands
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rs_reg    <= qpbsi_pkg::RS_IDLE;
      rp1_v_reg <= 1'b0;
      rp1_a_reg <= '0;
      rp2_v_reg <= 1'b0;
      rp2_a_reg <= '0;
      ra_reg    <= '0;
    end else begin
      rs_reg <= rs_next;
      if (k_rise) begin
        rp1_v_reg <= rd_cmd;
        rp1_a_reg <= rd_cmd ? addr_s : rp1_a_reg;
        rp2_v_reg <= rp1_v_reg;
        rp2_a_reg <= rp1_a_reg;
      end
      if (rd_b0) begin
        ra_reg <= rp2_a_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-lane memory with forwarding from the write buffer

  genvar gl;
  generate
    for (gl = 0; gl < `QPB_LANES; gl = gl + 1) begin : g_lane
      logic [`QPB_LANE_W-1:0] lane_mem [`QPB_MEM_DEPTH];
      logic                   fwd_stg;
      logic                   fwd_hd;

      // newest copy wins: staging, then buffer head, then array
      assign fwd_stg = stg_v_reg & (stg_wa == fetch_wa) & ~stg_bw_n[gl];
      assign fwd_hd  = buf_out_valid & (hd_wa == fetch_wa) & ~hd_bw_n[gl];
      assign fetch_word[gl*`QPB_LANE_W +: `QPB_LANE_W] =
        fwd_stg ? stg_d[gl*`QPB_LANE_W +: `QPB_LANE_W] :
        fwd_hd  ? hd_d[gl*`QPB_LANE_W +: `QPB_LANE_W] :
                  lane_mem[fetch_wa];

      // a low lane enable writes the byte, a high one skips it
      always_ff @(posedge clk_i) begin
        if (mem_we & ~hd_bw_n[gl]) begin
          lane_mem[hd_wa] <= hd_d[gl*`QPB_LANE_W +: `QPB_LANE_W];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // output registers: data, echo clocks and valid flag move together

  logic [`QPB_DATA_W-1:0]  q_reg;
  logic                    echo_p_reg;
  logic                    echo_n_reg;
  logic                    output_valid_flag_reg;

  assign read_data_bus_o     = q_reg;
  assign echo_out_pos_o      = echo_p_reg;
  assign echo_out_neg_o      = echo_n_reg;
  assign output_valid_flag_o = output_valid_flag_reg;

  // echo clocks follow the sampled link clocks on the data update edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_reg      <= '0;
      echo_p_reg <= 1'b0;
      echo_n_reg <= 1'b0;
      output_valid_flag_reg   <= 1'b0;
    end else begin
      echo_p_reg <= k_s;
      echo_n_reg <= kn_s;
      if (fetch_en) begin
        q_reg <= fetch_word;
      end
      if (k_rise | kn_rise) begin
        output_valid_flag_reg <= fetch_en;
      end
    end
  end

endmodule

// ### logic/qpbsi_defs.svh
// qpbsi_defs.svh: widths, field positions and reset values of the
// burst-of-four separate-I/O sram interface.
// assumes inclusion by bare name from every file that needs the numbers.
`ifndef QPBSI_DEFS_SVH
`define QPBSI_DEFS_SVH

// pin widths, word address width and memory depth
`define QPB_ADDR_W      19
`define QPB_LANES       4
`define QPB_LANE_W      9
`define QPB_DATA_W      36
`define QPB_BEAT_W      2
`define QPB_WORD_A_W    21
`define QPB_MEM_DEPTH   2097152

// layout of the synchronised pin vector
`define QPB_PIN_W       63
`define QPB_PIN_K       62
`define QPB_PIN_KN      61
`define QPB_PIN_RD_N    60
`define QPB_PIN_WR_N    59
`define QPB_PIN_A_HI    58
`define QPB_PIN_A_LO    40
`define QPB_PIN_BW_HI   39
`define QPB_PIN_BW_LO   36
`define QPB_PIN_D_HI    35
`define QPB_PIN_D_LO    0

// pin vector after reset: clocks low, requests and lane enables idle high
`define QPB_PIN_RST     63'h1800_00F0_0000_0000

// write beat payload: word address, lane enables, data
`define QPB_BEAT_PW     61

// buffer depth
`define QPB_BUF_DEPTH   2
`define QPB_BUF_PTR_W   1
`define QPB_BUF_CNT_W   2

`endif

// ### logic/qpbsi_pkg.sv
// qpbsi_pkg: state types of the burst-of-four sram interface.
// assumes nothing of its surroundings.
package qpbsi_pkg;

  // read burst output sequencer
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_B1   = 2'b01,
    RS_B2   = 2'b10,
    RS_B3   = 2'b11
  } qpbsi_rd_state_t;

  // write burst capture sequencer
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_B1   = 2'b01,
    WS_B2   = 2'b10,
    WS_B3   = 2'b11
  } qpbsi_wr_state_t;

endpackage

// ### logic/qpbsi_pin_sync.sv
// qpbsi_pin_sync: three-stage sampler for a vector of asynchronous pins.
// assumes the pins are slow against clk_i; a bit changes once stages two
// and three agree on it.
`timescale 1ns/1ps
`include "qpbsi_defs.svh"

module qpbsi_pin_sync #(
  parameter int               W       = `QPB_PIN_W,
  parameter logic [W-1:0]     RST_VAL = `QPB_PIN_RST
) (
  input  wire logic           clk_i,
  input  wire logic           sys_rst_i,
  input  wire logic [W-1:0]   pins_i,
  output logic      [W-1:0]   stable_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] stable_next;

  // a bit follows only where the two later stages agree
  assign stable_next = (s2_reg & s3_reg) |
                       (stable_reg & (s2_reg ^ s3_reg));
  assign stable_o    = stable_reg;

  // sampling chain; the first stage feeds only the second
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_reg     <= RST_VAL;
      s2_reg     <= RST_VAL;
      s3_reg     <= RST_VAL;
      stable_reg <= RST_VAL;
    end else begin
      s1_reg     <= pins_i;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

endmodule

// ### logic/qpbsi_skid_buf.sv
// qpbsi_skid_buf: two-entry first-in first-out buffer with valid/ready
// on both sides.
// assumes a single clock; out_data_o shows the head entry while valid.
`timescale 1ns/1ps
`include "qpbsi_defs.svh"

module qpbsi_skid_buf #(
  parameter int              W = `QPB_BEAT_PW
) (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire logic [W-1:0]  in_data_i,
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output logic      [W-1:0]  out_data_o
);

  logic [W-1:0]                 entry_reg [`QPB_BUF_DEPTH];
  logic [`QPB_BUF_PTR_W-1:0]    wr_ptr_reg;
  logic [`QPB_BUF_PTR_W-1:0]    rd_ptr_reg;
  logic [`QPB_BUF_CNT_W-1:0]    cnt_reg;
  logic                         push;
  logic                         pop;

  // honest full and empty from the fill count
  assign in_ready_o  = (cnt_reg != `QPB_BUF_CNT_W'(`QPB_BUF_DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = entry_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      entry_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and count
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop & ~push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule

// ### sim/qpbsi_host_model.sv
// qpbsi_host_model: memory controller model for the link side of qpbsi_top.
// assumes the bench queues one command slot per true clock rise and keeps
// writes and reads at least two rises apart; pins move at falling edges.
`timescale 1ns/1ps
`include "qpbsi_defs.svh"

module qpbsi_host_model (
  input  wire logic                   clk_i,
  input  wire logic                   run_i,
  output logic                        clk_k_o,
  output logic                        clk_k_n_o,
  output logic                        read_req_n_o,
  output logic                        write_req_n_o,
  output logic [`QPB_ADDR_W-1:0]      addr_o,
  output logic [`QPB_LANES-1:0]       lanes_n_o,
  output logic [`QPB_DATA_W-1:0]      data_o
);
  localparam int BW = `QPB_LANES + `QPB_DATA_W;
  logic [1:0]                 op_q [$];
  logic [`QPB_ADDR_W-1:0]     ad_q [$];
  logic [BW-1:0]              wb_q [$];
  logic [BW-1:0]              bt_q [$];
  logic [1:0]                 op;
  int                         ph;

  //////////////////////////////////////////////////////////////////////////
  // queue one slot: 0 idle, 1 read, 2 write with its four beats
  task automatic push(input logic [1:0]             o,
                      input logic [`QPB_ADDR_W-1:0] a,
                      input logic [4*BW-1:0]        b);
    op_q.push_back(o);
    ad_q.push_back(a);
    for (int i = 0; i < 4; i++) begin
      if (o == 2'h2) wb_q.push_back(b[i*BW +: BW]);
    end
  endtask

  // next beat on even count at true edges, odd count at complement edges;
  // otherwise the released pins show the inverse of their last value
  task automatic put_beat(input bit k_edge);
    if (bt_q.size() != 0 && (bt_q.size() % 2 == (k_edge ? 0 : 1))) begin
      {lanes_n_o, data_o} <= bt_q.pop_front();
    end else begin
      {lanes_n_o, data_o} <= ~{lanes_n_o, data_o};
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  // pins idle until the bench starts the link
  initial begin
    ph = 0;
    op = 2'h0;
    clk_k_o = 1'b0;
    clk_k_n_o = 1'b0;
    read_req_n_o = 1'b1;
    write_req_n_o = 1'b1;
    addr_o = '0;
    lanes_n_o = '1;
    data_o = '0;
  end

  // link period of 25 system cycles; setup and hold of 6 cycles or more
  always @(negedge clk_i) begin
    if (run_i) begin
      ph = (ph == 24) ? 0 : ph + 1;
      clk_k_o <= (ph < 13);
      clk_k_n_o <= (ph >= 13);
      if (ph == 6) put_beat(1'b0);
      if (ph == 19) begin
        put_beat(1'b1);
        op = (op_q.size() != 0) ? op_q.pop_front() : 2'h0;
        addr_o <= (ad_q.size() != 0) ? ad_q.pop_front() : ~addr_o;
        read_req_n_o <= (op != 2'h1);
        write_req_n_o <= (op != 2'h2);
        if (op == 2'h2) repeat (4) bt_q.push_back(wb_q.pop_front());
      end
    end
  end
endmodule

// ### sim/qpbsi_top_monitor.sv
// qpbsi_top_monitor: pin-level checks of read timing and echo clocks.
// assumes the link pins are slow against clk_i and that the true and
// complement rises lie 12 to 13 system cycles apart.
`timescale 1ns/1ps
`include "qpbsi_defs.svh"

module qpbsi_top_monitor (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      clk_k_i,
  input  wire logic                      clk_k_n_i,
  input  wire logic                      read_req_n_i,
  input  wire logic                      write_req_n_i,
  input  wire logic [`QPB_ADDR_W-1:0]    address_inputs_i,
  input  wire logic [`QPB_LANES-1:0]     byte_lane_write_n_i,
  input  wire logic [`QPB_DATA_W-1:0]    write_data_bus_i,
  input  wire logic [`QPB_DATA_W-1:0]    read_data_bus_o,
  input  wire logic                      echo_out_pos_o,
  input  wire logic                      echo_out_neg_o,
  input  wire logic                      output_valid_flag_o
);
  logic          ep_reg;
  logic          en_reg;
  logic          kp_reg;
  logic [63:0]   rd_hist_reg;
  wire           pos_beat = echo_out_pos_o & ~ep_reg & output_valid_flag_o;
  wire           neg_beat = echo_out_neg_o & ~en_reg & output_valid_flag_o;
  wire           edge_any = (echo_out_pos_o & ~ep_reg)
                          | (echo_out_neg_o & ~en_reg);
  wire           vbeat    = pos_beat | neg_beat;
  wire           rd_cmd   = clk_k_i & ~kp_reg & ~read_req_n_i;

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  //////////////////////////////////////////////////////////////////////////
  // previous echo and clock levels, history of read commands
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ep_reg <= 1'b0;
      en_reg <= 1'b0;
      kp_reg <= 1'b0;
      rd_hist_reg <= '0;
    end else begin
      ep_reg <= echo_out_pos_o;
      en_reg <= echo_out_neg_o;
      kp_reg <= clk_k_i;
      rd_hist_reg <= {rd_hist_reg[62:0], rd_cmd};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // burst shape: first beat after two link cycles, then three more
  sequence first_beat;
    ##[50:62] pos_beat;
  endsequence
  sequence more_beat;
    ##[10:16] vbeat;
  endsequence

  a_echo_pos_track: assert property ($rose(clk_k_i) |->
    ##[3:8] $rose(echo_out_pos_o)) else $error("echo pos late");
  a_echo_neg_track: assert property ($rose(clk_k_n_i) |->
    ##[3:8] $rose(echo_out_neg_o)) else $error("echo neg late");
  a_data_on_beat: assert property ($changed(read_data_bus_o) |->
    vbeat) else $error("read data moved off a valid echo edge");
  a_valid_on_edge: assert property ($changed(output_valid_flag_o) |->
    edge_any) else $error("valid flag moved off an echo edge");
  a_read_latency: assert property (rd_cmd |-> first_beat)
    else $error("first read beat not two cycles after command");
  a_read_neg_beats: assert property (rd_cmd |-> ##[58:74] neg_beat)
    else $error("second read beat missing at complement edge");
  a_four_beats: assert property (rd_cmd |->
    first_beat ##0 more_beat ##0 more_beat ##0 more_beat)
    else $error("read burst not four beats");
  a_valid_needs_read: assert property ($rose(output_valid_flag_o) |->
    (|rd_hist_reg[61:49])) else $error("valid raised without a read");
endmodule

bind qpbsi_top qpbsi_top_monitor u_mon (
  .clk_i, .sys_rst_i, .clk_k_i, .clk_k_n_i, .read_req_n_i, .write_req_n_i,
  .address_inputs_i, .byte_lane_write_n_i, .write_data_bus_i,
  .read_data_bus_o, .echo_out_pos_o, .echo_out_neg_o, .output_valid_flag_o
);

// ### sim/qpbsi_bench.sv
// qpbsi_bench: self-checking bench for qpbsi_top with a host model.
// assumes qpbsi_host_model drives the link; a reference memory predicts
// every read beat from the writes queued before it.
`timescale 1ns/1ps
`include "qpbsi_defs.svh"

module qpbsi_bench;
  localparam int BW = `QPB_LANES + `QPB_DATA_W;
  logic                       clk_i;
  logic                       sys_rst_i;
  logic                       run;
  logic                       k;
  logic                       kn;
  logic                       rd_n;
  logic                       wr_n;
  logic [`QPB_ADDR_W-1:0]     addr;
  logic [`QPB_LANES-1:0]      bw_n;
  logic [`QPB_DATA_W-1:0]     wd;
  logic [`QPB_DATA_W-1:0]     rdata;
  logic                       ep;
  logic                       en;
  logic                       vld;
  logic                       ep_q;
  logic                       en_q;
  logic [`QPB_DATA_W-1:0]     mem [int];
  logic [`QPB_DATA_W-1:0]     exp_q [$];
  logic [`QPB_ADDR_W-1:0]     pool [4];
  logic [`QPB_ADDR_W-1:0]     last_a;
  logic [`QPB_ADDR_W-1:0]     a;
  int                         miscompares;
  int                         num_checks;
  int                         cycles;
  int                         beats;
  int                         sent;

  qpbsi_host_model host (.clk_i(clk_i), .run_i(run), .clk_k_o(k),
    .clk_k_n_o(kn), .read_req_n_o(rd_n), .write_req_n_o(wr_n),
    .addr_o(addr), .lanes_n_o(bw_n), .data_o(wd));

  qpbsi_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_k_i(k),
    .clk_k_n_i(kn), .read_req_n_i(rd_n), .write_req_n_i(wr_n),
    .address_inputs_i(addr), .byte_lane_write_n_i(bw_n),
    .write_data_bus_i(wd), .read_data_bus_o(rdata), .echo_out_pos_o(ep),
    .echo_out_neg_o(en), .output_valid_flag_o(vld));

  //////////////////////////////////////////////////////////////////////////
  // lanes whose enable is low take the new bytes
  function automatic logic [`QPB_DATA_W-1:0] merge(
    input logic [`QPB_DATA_W-1:0] old, input logic [`QPB_DATA_W-1:0] nw,
    input logic [`QPB_LANES-1:0] ln);
    merge = old;
    for (int l = 0; l < `QPB_LANES; l++) begin
      if (!ln[l]) merge[l*`QPB_LANE_W +: `QPB_LANE_W] =
                  nw[l*`QPB_LANE_W +: `QPB_LANE_W];
    end
  endfunction

  task automatic check_word(input logic [`QPB_DATA_W-1:0] got,
                            input logic [`QPB_DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // write burst with random data; full lanes or random lanes per beat
  task automatic do_write(input logic [`QPB_ADDR_W-1:0] wa, input bit full);
    logic [4*BW-1:0]        b;
    logic [`QPB_DATA_W-1:0] d;
    logic [`QPB_LANES-1:0]  l;
    int                     w;
    for (int i = 0; i < 4; i++) begin
      d = `QPB_DATA_W'({$urandom, $urandom});
      l = full ? 4'h0 : 4'($urandom);
      w = int'({wa, 2'(i)});
      mem[w] = merge(mem.exists(w) ? mem[w] : 'x, d, l);
      b[i*BW +: BW] = {l, d};
    end
    host.push(2'h2, wa, b);
  endtask

  task automatic do_read(input logic [`QPB_ADDR_W-1:0] ra);
    for (int i = 0; i < 4; i++) exp_q.push_back(mem[int'({ra, 2'(i)})]);
    sent += 4;
    host.push(2'h1, ra, '0);
  endtask

  task automatic do_nop();
    host.push(2'h0, `QPB_ADDR_W'($urandom), '0);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // clock, run limit, and capture of each valid read beat
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  always @(negedge clk_i) begin
    ep_q <= ep;
    en_q <= en;
    if ((((ep & !ep_q) | (en & !en_q)) & vld) === 1'b1) begin
      beats++;
      if (exp_q.size() != 0) check_word(rdata, exp_q.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fill a small pool, then interleave writes, reads and idle slots
  initial begin
    sys_rst_i = 1'b1;
    run = 1'b0;
    void'($urandom(32'h1BFA));
    repeat (10) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    run = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pool[i] = `QPB_ADDR_W'($urandom);
      do_write(pool[i], 1'b1);
      do_nop();
    end
    last_a = pool[3];
    for (int i = 0; i < 30; i++) begin
      a = pool[$urandom_range(3)];
      do_write(a, 1'b0);
      do_read(last_a);
      last_a = a;
      if (i % 3 == 2) begin
        do_nop();
        do_nop();
      end
    end
    do_nop();
    do_read(last_a);
    while (exp_q.size() != 0) @(negedge clk_i);
    repeat (150) @(negedge clk_i);
    check_count(beats, sent);
    complete_run();
  end
endmodule
